/* hw/amq_alu.sv */
// byte-sliced alu function unit with carry chain broken at word boundaries
`timescale 1ns/100ps
`default_nettype none
module amq_alu (
   // function select
   input wire amq_pkg::amq_func_e func,
   input wire logic carry_in,
   input wire logic [3:0] base_mask,
   // operands
   input wire logic [31:0] r_operand,
   input wire logic [31:0] s_operand,
   // result and per byte carry and overflow
   output logic [31:0] alu_f,
   output logic [3:0] carry_vec,
   output logic [3:0] ovr_vec
);
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [31:0] logic_f;
   logic arith;
   logic [3:0] byte_cin;
   logic [3:0] byte_cout;
   logic [31:0] sum_f;

   always_comb begin
      op_a = amq_pkg::ZERO_WORD;
      op_b = amq_pkg::ZERO_WORD;
      logic_f = amq_pkg::ZERO_WORD;
      arith = 1'b1;
      case (func)
         amq_pkg::FN_ADD: begin op_a = r_operand; op_b = s_operand; end
         amq_pkg::FN_SUBR: begin op_a = ~r_operand; op_b = s_operand; end
         amq_pkg::FN_SUBS: begin op_a = r_operand; op_b = ~s_operand; end
         amq_pkg::FN_INCS: op_b = s_operand;
         amq_pkg::FN_INCNS: op_b = ~s_operand;
         amq_pkg::FN_INCR: op_a = r_operand;
         amq_pkg::FN_INCNR: op_a = ~r_operand;
         default: begin
            arith = 1'b0;
            case (func)
               amq_pkg::FN_XOR: logic_f = r_operand ^ s_operand;
               amq_pkg::FN_AND: logic_f = r_operand & s_operand;
               amq_pkg::FN_OR: logic_f = r_operand | s_operand;
               amq_pkg::FN_NAND: logic_f = ~(r_operand & s_operand);
               amq_pkg::FN_NOR: logic_f = ~(r_operand | s_operand);
               amq_pkg::FN_ANDNR: logic_f = ~r_operand & s_operand;
               amq_pkg::FN_PASS_S: logic_f = s_operand;
               amq_pkg::FN_PASS_R: logic_f = r_operand;
               default: logic_f = amq_pkg::ZERO_WORD;
            endcase
         end
      endcase
   end

   // ----------------------------------------------------------------
   // byte slices; carry_in enters at the base byte of every word
   // ----------------------------------------------------------------
   for (genvar k = 0; k < amq_pkg::NUM_BYTES; k++) begin : g_slice
      logic [8:0] sum;
      logic [7:0] a;
      logic [7:0] b;
      if (k == 0) begin : g_first
         assign byte_cin[k] = carry_in;
      end else begin : g_chain
         // the carry rides a net so the chain re-evaluates whenever an operand moves
         assign byte_cin[k] = base_mask[k] ? carry_in : byte_cout[k - 1];
      end
      assign a = op_a[8*k +: 8];
      assign b = op_b[8*k +: 8];
      assign sum = {1'b0, a} + {1'b0, b} + {8'h00, byte_cin[k]};
      assign sum_f[8*k +: 8] = sum[7:0];
      assign byte_cout[k] = sum[8];
      assign carry_vec[k] = arith & byte_cout[k];
      assign ovr_vec[k] = arith & (a[7] == b[7]) & (sum[7] != a[7]);
   end

   assign alu_f = arith ? sum_f : logic_f;
endmodule
`default_nettype wire

/* hw/amq_pkg.sv */
// shared constants, types and encodings of the mq shift and normalize stage
package amq_pkg;

   // ----------------------------------------------------------------
   // datapath geometry
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int NUM_BYTES = 4;
   localparam int BYTE_MSB = 7;
   localparam int SIGN_POS = 31;
   localparam int NEXT_POS = 30;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] Y_RESET = 32'h0000_0000;
   localparam logic [31:0] MQ_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] ONES_WORD = 32'hFFFF_FFFF;

   // ----------------------------------------------------------------
   // word size configuration and byte masks
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WS_BYTE = 2'h0,
      WS_HALF = 2'h1,
      WS_WORD = 2'h2
   } amq_wsize_e;

   // byte k is the most significant byte of its word
   localparam logic [3:0] TOP_MASK_BYTE = 4'hF;
   localparam logic [3:0] TOP_MASK_HALF = 4'hA;
   localparam logic [3:0] TOP_MASK_WORD = 4'h8;
   // byte k is the least significant byte of its word
   localparam logic [3:0] BASE_MASK_BYTE = 4'hF;
   localparam logic [3:0] BASE_MASK_HALF = 4'h5;
   localparam logic [3:0] BASE_MASK_WORD = 4'h1;

   // ----------------------------------------------------------------
   // instructions and alu functions
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_PASS = 3'h0,
      OP_LOAD_MQ = 3'h1,
      OP_NORMALIZE = 3'h2,
      OP_SRA_SINGLE = 3'h3,
      OP_SRA_DOUBLE = 3'h4
   } amq_op_e;

   typedef enum logic [3:0] {
      FN_ADD = 4'h0,
      FN_SUBR = 4'h1,
      FN_SUBS = 4'h2,
      FN_INCS = 4'h3,
      FN_INCNS = 4'h4,
      FN_INCR = 4'h5,
      FN_INCNR = 4'h6,
      FN_XOR = 4'h7,
      FN_AND = 4'h8,
      FN_OR = 4'h9,
      FN_NAND = 4'hA,
      FN_NOR = 4'hB,
      FN_ANDNR = 4'hC,
      FN_PASS_S = 4'hD,
      FN_PASS_R = 4'hE,
      FN_CLEAR = 4'hF
   } amq_func_e;

   typedef struct packed {
      amq_op_e op;
      amq_func_e func;
      logic carry_in;
      logic shift_condition_input;
   } amq_instr_s;

   typedef struct packed {
      logic zero;
      logic negative;
      logic carry;
      logic overflow_flag;
   } amq_status_s;

   localparam amq_status_s STATUS_RESET = '{zero: 1'b0, negative: 1'b0, carry: 1'b0, overflow_flag: 1'b0};

endpackage

/* hw/amq_shift.sv */
// per-bit shift network: arithmetic right (single and double) and mq left normalize
`timescale 1ns/100ps
`default_nettype none
module amq_shift (
   // word layout
   input wire logic [3:0] top_mask,
   input wire logic [3:0] base_mask,
   // data in
   input wire logic [31:0] alu_f,
   input wire logic [3:0] ovr_vec,
   input wire logic [31:0] mq,
   // shifted values
   output logic [31:0] alu_sh,
   output logic [31:0] mq_sh,
   output logic [31:0] mq_norm,
   output logic [3:0] word_done
);
   logic [3:0] word_lsb;
   logic [3:0] byte_done;

   for (genvar k = 0; k < amq_pkg::NUM_BYTES; k++) begin : g_byte
      // alu lsb of the word holding byte k, carried upward from the base byte
      if (k == 0) begin : g_lo
         assign word_lsb[k] = alu_f[0];
      end else begin : g_up
         assign word_lsb[k] = base_mask[k] ? alu_f[8*k] : word_lsb[k-1];
      end
      // normalized state of the word, carried downward from its top byte
      assign word_done[k] = mq[8*k+7] ^ mq[8*k+6];
      if (k == amq_pkg::NUM_BYTES - 1) begin : g_hi
         assign byte_done[k] = word_done[k];
      end else begin : g_dn
         assign byte_done[k] = top_mask[k] ? word_done[k] : byte_done[k+1];
      end
   end

   for (genvar j = 0; j < amq_pkg::DATA_W; j++) begin : g_bit
      localparam int K = j / amq_pkg::BYTE_W;
      localparam int B = j % amq_pkg::BYTE_W;
      logic left_bit;
      if (B == amq_pkg::BYTE_MSB) begin : g_msb
         if (j == amq_pkg::SIGN_POS) begin : g_sign
            assign alu_sh[j] = alu_f[j] ^ ovr_vec[K];
            assign mq_sh[j] = word_lsb[K];
         end else begin : g_inner
            assign alu_sh[j] = top_mask[K] ? (alu_f[j] ^ ovr_vec[K]) : alu_f[j+1];
            assign mq_sh[j] = top_mask[K] ? word_lsb[K] : mq[j+1];
         end
      end else begin : g_body
         // bit 0 of the lowest byte of each word falls off the end here
         assign alu_sh[j] = alu_f[j+1];
         assign mq_sh[j] = mq[j+1];
      end
      if (B == 0) begin : g_fill
         if (j == 0) begin : g_zero
            assign left_bit = 1'b0;
         end else begin : g_join
            assign left_bit = base_mask[K] ? 1'b0 : mq[j-1];
         end
      end else begin : g_pass
         assign left_bit = mq[j-1];
      end
      // a word that is already normalized keeps its bits
      assign mq_norm[j] = byte_done[K] ? mq[j] : left_bit;
   end
endmodule
`default_nettype wire

/* hw/amq_top.sv */
// mq normalize and arithmetic right shift stage of a byte-sliced registered alu
`timescale 1ns/100ps
`default_nettype none
module amq_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // instruction from the sequencer
   input wire logic instr_valid,
   input wire amq_pkg::amq_instr_s instr,
   input wire amq_pkg::amq_wsize_e word_size,
   // operands
   input wire logic [31:0] r_operand,
   input wire logic [31:0] s_operand,
   // results
   output logic [31:0] result_output_mux,
   output logic [31:0] multiplier_quotient_register,
   output amq_pkg::amq_status_s status,
   output logic normalize_done
);

   // ----------------------------------------------------------------
   // word layout decode
   // ----------------------------------------------------------------
   logic [3:0] top_mask;
   logic [3:0] base_mask;

   always_comb begin
      if (word_size == amq_pkg::WS_BYTE) begin
         top_mask = amq_pkg::TOP_MASK_BYTE;
         base_mask = amq_pkg::BASE_MASK_BYTE;
      end else if (word_size == amq_pkg::WS_HALF) begin
         top_mask = amq_pkg::TOP_MASK_HALF;
         base_mask = amq_pkg::BASE_MASK_HALF;
      end else begin
         // an unused size code falls back to the full word
         top_mask = amq_pkg::TOP_MASK_WORD;
         base_mask = amq_pkg::BASE_MASK_WORD;
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   logic [31:0] y_reg;
   logic [31:0] y_next;
   logic [31:0] mq_reg;
   logic [31:0] mq_next;
   amq_pkg::amq_status_s status_reg;
   amq_pkg::amq_status_s status_next;
   logic done_reg;
   logic done_next;

   // ----------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------
   logic is_norm;
   logic is_sra;
   logic is_double;
   logic top_done;
   amq_pkg::amq_func_e func_eff;
   logic cin_eff;
   logic [3:0] word_done;

   assign is_norm = (instr.op == amq_pkg::OP_NORMALIZE);
   assign is_sra = (instr.op == amq_pkg::OP_SRA_SINGLE) || (instr.op == amq_pkg::OP_SRA_DOUBLE);
   assign is_double = (instr.op == amq_pkg::OP_SRA_DOUBLE);
   // the count tracks the most significant word of mq
   assign top_done = word_done[amq_pkg::NUM_BYTES-1];

   always_comb begin
      if (is_norm) begin
         // count path is s plus carry; a finished number gets no increment
         func_eff = amq_pkg::FN_INCS;
         cin_eff = instr.carry_in & ~top_done;
      end else begin
         // carry_in reaches only the function chosen by the instruction
         func_eff = instr.func;
         cin_eff = instr.carry_in;
      end
   end

   // ----------------------------------------------------------------
   // alu and shift network
   // ----------------------------------------------------------------
   logic [31:0] alu_f;
   logic [3:0] carry_vec;
   logic [3:0] ovr_vec;
   logic [31:0] alu_sh;
   logic [31:0] mq_sh;
   logic [31:0] mq_norm;

   amq_alu u_alu (
      .func(func_eff),
      .carry_in(cin_eff),
      .base_mask(base_mask),
      .r_operand(r_operand),
      .s_operand(s_operand),
      .alu_f(alu_f),
      .carry_vec(carry_vec),
      .ovr_vec(ovr_vec)
   );

   amq_shift u_shift (
      .top_mask(top_mask),
      .base_mask(base_mask),
      .alu_f(alu_f),
      .ovr_vec(ovr_vec),
      .mq(mq_reg),
      .alu_sh(alu_sh),
      .mq_sh(mq_sh),
      .mq_norm(mq_norm),
      .word_done(word_done)
   );

   // ----------------------------------------------------------------
   // result selection
   // ----------------------------------------------------------------
   logic take_shift;
   logic [31:0] sel_y;
   logic alu_carry;
   logic alu_ovr;

   // a floating select pin must be pulled high at the pad to read as shift
   assign take_shift = instr.shift_condition_input;
   assign alu_carry = carry_vec[amq_pkg::NUM_BYTES-1];
   assign alu_ovr = ovr_vec[amq_pkg::NUM_BYTES-1];

   always_comb begin
      if (is_sra && take_shift) begin
         sel_y = alu_sh;
      end else begin
         sel_y = alu_f;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      y_next = y_reg;
      mq_next = mq_reg;
      status_next = status_reg;
      done_next = done_reg;
      if (instr_valid) begin
         case (instr.op)
            amq_pkg::OP_PASS: begin
               y_next = alu_f;
               status_next.zero = (alu_f == amq_pkg::ZERO_WORD);
               status_next.negative = alu_f[amq_pkg::SIGN_POS];
               status_next.carry = alu_carry;
               status_next.overflow_flag = alu_ovr;
            end
            amq_pkg::OP_LOAD_MQ: begin
               y_next = alu_f;
               mq_next = alu_f;
               status_next.zero = (alu_f == amq_pkg::ZERO_WORD);
               status_next.negative = alu_f[amq_pkg::SIGN_POS];
               status_next.carry = alu_carry;
               status_next.overflow_flag = alu_ovr;
            end
            amq_pkg::OP_NORMALIZE: begin
               y_next = alu_f;
               mq_next = mq_norm;
               status_next.negative = mq_reg[amq_pkg::SIGN_POS];
               status_next.overflow_flag = mq_reg[amq_pkg::SIGN_POS] ^ mq_reg[amq_pkg::NEXT_POS];
               status_next.carry = alu_carry;
               status_next.zero = (alu_f == amq_pkg::ZERO_WORD);
               done_next = top_done;
            end
            amq_pkg::OP_SRA_SINGLE, amq_pkg::OP_SRA_DOUBLE: begin
               y_next = sel_y;
               if (is_double && take_shift) begin
                  // lower half moves together with the upper half
                  mq_next = mq_sh;
               end
               status_next.zero = (sel_y == amq_pkg::ZERO_WORD);
               status_next.negative = sel_y[amq_pkg::SIGN_POS];
               status_next.carry = alu_carry;
               // the sign is already corrected, so no overflow is reported
               status_next.overflow_flag = 1'b0;
            end
            default: begin
               y_next = y_reg;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         y_reg <= amq_pkg::Y_RESET;
         mq_reg <= amq_pkg::MQ_RESET;
         status_reg <= amq_pkg::STATUS_RESET;
         done_reg <= 1'b0;
      end else begin
         y_reg <= y_next;
         mq_reg <= mq_next;
         status_reg <= status_next;
         done_reg <= done_next;
      end
   end

   assign result_output_mux = y_reg;
   assign multiplier_quotient_register = mq_reg;
   assign status = status_reg;
   assign normalize_done = done_reg;

endmodule
`default_nettype wire

/* sim/amq_properties.sv */
// concurrent checks on the ports of the mq normalize and arithmetic shift stage
`timescale 1ns/100ps
`default_nettype none
module amq_properties (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // instruction and operands
   input wire logic instr_valid,
   input wire amq_pkg::amq_instr_s instr,
   input wire amq_pkg::amq_wsize_e word_size,
   input wire logic [31:0] r_operand,
   input wire logic [31:0] s_operand,
   // results
   input wire logic [31:0] result_output_mux,
   input wire logic [31:0] multiplier_quotient_register,
   input wire amq_pkg::amq_status_s status,
   input wire logic normalize_done
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic norm;
   logic sra1;
   logic sra2;
   logic plain;
   logic [31:0] mq;
   assign mq = multiplier_quotient_register;
   assign norm = instr_valid && instr.op == amq_pkg::OP_NORMALIZE && word_size == amq_pkg::WS_WORD;
   assign sra1 = instr_valid && instr.op == amq_pkg::OP_SRA_SINGLE;
   assign sra2 = instr_valid && instr.op == amq_pkg::OP_SRA_DOUBLE;
   // pass of r has no overflow, so the sign bit must simply be kept
   assign plain = word_size == amq_pkg::WS_WORD && instr.func == amq_pkg::FN_PASS_R && instr.shift_condition_input;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   chk_idle_hold: assert property ((!instr_valid || instr.op > amq_pkg::OP_SRA_DOUBLE) |=>
      $stable(result_output_mux) && $stable(mq) && $stable(status) && $stable(normalize_done))
      else $error("state changed without an instruction");
   chk_norm_shift: assert property (norm && mq[31] == mq[30] && instr.carry_in |=>
      mq == {$past(mq[30:0]), 1'b0} && result_output_mux == $past(s_operand) + 32'h0000_0001)
      else $error("normalize shift or count wrong");
   chk_norm_inhibit: assert property (norm && mq[31] != mq[30] |=>
      $stable(mq) && result_output_mux == $past(s_operand) && normalize_done)
      else $error("normalized number was not left alone");
   chk_norm_neg: assert property (norm |=> status.negative == $past(mq[31]))
      else $error("normalize negative flag wrong");
   chk_norm_ovr: assert property (norm |=> status.overflow_flag == $past(mq[31] ^ mq[30]))
      else $error("normalize overflow flag wrong");
   chk_norm_zero: assert property (norm |=> status.zero == (result_output_mux == 32'h0000_0000))
      else $error("normalize zero flag wrong");
   chk_sra_sign: assert property (sra1 && plain |=>
      result_output_mux == {$past(r_operand[31]), $past(r_operand[31:1])})
      else $error("single shift lost the sign");
   chk_sra_bypass: assert property (sra1 && !instr.shift_condition_input && instr.func == amq_pkg::FN_PASS_S |=>
      result_output_mux == $past(s_operand))
      else $error("unshifted result not passed");
   chk_dbl_mq: assert property (sra2 && plain |=> mq == {$past(r_operand[0]), $past(mq[31:1])})
      else $error("double shift lower half wrong");
   chk_dbl_hold: assert property (sra2 && !instr.shift_condition_input |=> $stable(mq))
      else $error("lower half changed without shift");
   chk_shift_flags: assert property (sra1 || sra2 |=>
      status.negative == result_output_mux[31] && !status.overflow_flag)
      else $error("shift sign or overflow flag wrong");
endmodule
bind amq_top amq_properties chk (
   .sys_clk(sys_clk),
   .reset(reset),
   .instr_valid(instr_valid),
   .instr(instr),
   .word_size(word_size),
   .r_operand(r_operand),
   .s_operand(s_operand),
   .result_output_mux(result_output_mux),
   .multiplier_quotient_register(multiplier_quotient_register),
   .status(status),
   .normalize_done(normalize_done)
);
`default_nettype wire

/* sim/amq_seq_model.sv */
// sequencer model that presents one instruction a clock to the stage
`timescale 1ns/100ps
`default_nettype none
module amq_seq_model (
   // clock
   input wire logic sys_clk,
   // instruction and operands
   output logic instr_valid,
   output var amq_pkg::amq_instr_s instr,
   output var amq_pkg::amq_wsize_e word_size,
   output logic [31:0] r_operand,
   output logic [31:0] s_operand,
   // high in each cycle whose result is checked
   output logic noted
);
   initial begin
      instr_valid = 1'b0;
      instr = '0;
      word_size = amq_pkg::WS_WORD;
      r_operand = 32'h0000_0000;
      s_operand = 32'h0000_0000;
      noted = 1'b0;
   end
   // fields move just after an edge and stand whole for the cycle
   task automatic send(input logic v, input amq_pkg::amq_op_e op, input amq_pkg::amq_func_e fn, input logic c,
         input logic sc, input amq_pkg::amq_wsize_e ws, input logic [31:0] r, input logic [31:0] s);
      @(posedge sys_clk);
      instr_valid <= v;
      // normalize counts unless the number is already normalized, so its carry is driven high; the other fields pass as given
      instr <= '{op: op, func: fn, carry_in: (op == amq_pkg::OP_NORMALIZE) ? 1'b1 : c, shift_condition_input: sc};
      word_size <= ws;
      r_operand <= r;
      s_operand <= s;
      noted <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* sim/amq_top_bench.sv */
// self-checking bench for the mq normalize and arithmetic shift stage
`timescale 1ns/100ps
`default_nettype none
module amq_top_bench;
   typedef struct packed {
      logic [31:0] y;
      logic [31:0] mq;
      amq_pkg::amq_status_s st;
      logic nd;
   } amq_note_s;
   logic sys_clk;
   logic reset;
   logic instr_valid;
   amq_pkg::amq_instr_s instr;
   amq_pkg::amq_wsize_e word_size;
   logic [31:0] r_operand;
   logic [31:0] s_operand;
   logic [31:0] result_output_mux;
   logic [31:0] multiplier_quotient_register;
   amq_pkg::amq_status_s status;
   logic normalize_done;
   logic noted;
   int n_mismatch = 0;
   int n_compared = 0;
   amq_note_s notes[$];
   amq_note_s ex = '0;
   amq_pkg::amq_func_e fns[3] = '{amq_pkg::FN_ADD, amq_pkg::FN_PASS_R, amq_pkg::FN_PASS_S};
   amq_pkg::amq_op_e ops[3] = '{amq_pkg::OP_LOAD_MQ, amq_pkg::OP_SRA_SINGLE, amq_pkg::OP_SRA_DOUBLE};
   amq_pkg::amq_wsize_e wss[3] = '{amq_pkg::WS_BYTE, amq_pkg::WS_HALF, amq_pkg::WS_WORD};
   amq_top dut (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .word_size(word_size),
      .r_operand(r_operand), .s_operand(s_operand), .result_output_mux(result_output_mux),
      .multiplier_quotient_register(multiplier_quotient_register), .status(status), .normalize_done(normalize_done));
   amq_seq_model seq (.sys_clk(sys_clk), .instr_valid(instr_valid), .instr(instr), .word_size(word_size),
      .r_operand(r_operand), .s_operand(s_operand), .noted(noted));
   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // reference model: per word alu, shift, flags
   // ------------------------------------------------------------
   task automatic issue(input logic v, input amq_pkg::amq_op_e op, input amq_pkg::amq_func_e fn, input logic c,
         input logic sc, input amq_pkg::amq_wsize_e ws, input logic [31:0] r, input logic [31:0] s);
      int w;
      logic [31:0] m, a, b, f, q, sh;
      logic [32:0] t;
      logic cy, ov, sop;
      w = (ws == amq_pkg::WS_BYTE) ? 8 : (ws == amq_pkg::WS_HALF) ? 16 : 32;
      m = 32'hFFFF_FFFF >> (32 - w);
      sop = op == amq_pkg::OP_SRA_SINGLE || op == amq_pkg::OP_SRA_DOUBLE;
      f = 32'h0000_0000;
      q = 32'h0000_0000;
      for (int k = 0; k < 32; k += w) begin
         a = (r >> k) & m;
         b = (s >> k) & m;
         t = (fn == amq_pkg::FN_ADD) ? {1'b0, a} + {1'b0, b} + 33'(c) : {1'b0, (fn == amq_pkg::FN_PASS_R) ? a : b};
         cy = t[w];
         ov = fn == amq_pkg::FN_ADD && a[w-1] == b[w-1] && t[w-1] != a[w-1];
         sh = ((t[31:0] & m) >> 1) | (32'(t[w-1] ^ ov) << (w - 1));
         f |= ((sop && sc) ? sh : (t[31:0] & m)) << k;
         q |= ((((ex.mq >> k) & m) >> 1) | (32'(t[0]) << (w - 1))) << k;
      end
      if (!(op == amq_pkg::OP_SRA_DOUBLE && sc)) q = (op == amq_pkg::OP_LOAD_MQ) ? f : ex.mq;
      if (v && op <= amq_pkg::OP_SRA_DOUBLE) begin
         if (op == amq_pkg::OP_NORMALIZE) begin
            t = {1'b0, s} + {32'h0000_0000, ex.mq[31] == ex.mq[30]};
            f = t[31:0];
            cy = t[32];
            ov = ex.mq[31] ^ ex.mq[30];
            ex.nd = ov;
            q = ov ? ex.mq : {ex.mq[30:0], 1'b0};
         end
         ex.st = '{zero: f == 32'h0000_0000, negative: (op == amq_pkg::OP_NORMALIZE) ? ex.mq[31] : f[31],
            carry: cy, overflow_flag: sop ? 1'b0 : ov};
         ex.y = f;
         ex.mq = q;
      end
      notes.push_back(ex);
      seq.send(v, op, fn, c, sc, ws, r, s);
   endtask
   // ------------------------------------------------------------
   // clock, watchdog, monitor
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      amq_note_s nt;
      forever begin
         @(posedge sys_clk);
         if (noted && !reset) begin
            #1;
            nt = notes.pop_front();
            check("result", result_output_mux, nt.y);
            check("mq", multiplier_quotient_register, nt.mq);
            check("negative", 32'(status.negative), 32'(nt.st.negative));
            check("carry", 32'(status.carry), 32'(nt.st.carry));
            check("overflow", 32'(status.overflow_flag), 32'(nt.st.overflow_flag));
            check("done", 32'(normalize_done), 32'(nt.nd));
            check("zero", 32'(status.zero), 32'(nt.st.zero));
         end
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      void'($urandom(71131));
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      check("reset result", result_output_mux, 32'h0000_0000);
      check("reset mq", multiplier_quotient_register, 32'h0000_0000);
      check("reset flags", 32'({status, normalize_done}), 32'h0000_0000);
      issue(1, amq_pkg::OP_LOAD_MQ, amq_pkg::FN_PASS_R, 0, 1, amq_pkg::WS_WORD, 32'h3699_D84E, 32'h0000_0000);
      issue(1, amq_pkg::OP_NORMALIZE, amq_pkg::FN_INCS, 1, 1, amq_pkg::WS_WORD, 32'h0000_0000, 32'h0000_0003);
      issue(1, amq_pkg::OP_NORMALIZE, amq_pkg::FN_INCS, 1, 1, amq_pkg::WS_WORD, 32'h0000_0000, 32'h0000_0004);
      issue(1, amq_pkg::OP_LOAD_MQ, amq_pkg::FN_PASS_R, 0, 1, amq_pkg::WS_WORD, 32'h0000_0000, 32'h0000_0000);
      issue(1, amq_pkg::OP_NORMALIZE, amq_pkg::FN_INCS, 1, 1, amq_pkg::WS_WORD, 32'h0000_0000, 32'hFFFF_FFFF);
      issue(1, amq_pkg::OP_SRA_SINGLE, amq_pkg::FN_ADD, 0, 1, amq_pkg::WS_WORD, 32'h6A08_C618, 32'h5100_7530);
      issue(1, amq_pkg::OP_SRA_SINGLE, amq_pkg::FN_ADD, 0, 0, amq_pkg::WS_WORD, 32'h6A08_C618, 32'h5100_7530);
      issue(1, amq_pkg::OP_LOAD_MQ, amq_pkg::FN_PASS_R, 0, 1, amq_pkg::WS_WORD, 32'h1729_9A0F, 32'h0000_0000);
      issue(1, amq_pkg::OP_SRA_DOUBLE, amq_pkg::FN_ADD, 0, 1, amq_pkg::WS_WORD, 32'h4A08_C618, 32'h5100_7530);
      issue(0, amq_pkg::OP_SRA_DOUBLE, amq_pkg::FN_ADD, 1, 1, amq_pkg::WS_WORD, $urandom, $urandom);
      issue(1, amq_pkg::amq_op_e'(3'h5), amq_pkg::FN_ADD, 1, 1, amq_pkg::WS_WORD, $urandom, $urandom);
      issue(1, amq_pkg::OP_PASS, amq_pkg::FN_ADD, 1, 1, amq_pkg::WS_HALF, $urandom, $urandom);
      // every word size, the load mq and both shift instructions, add, pass r and pass s, and both shift conditions with random data
      for (int i = 0; i < 54; i++) begin
         issue(1, ops[(i / 6) % 3], fns[(i / 2) % 3], 1'($urandom), i % 2 == 1, wss[i / 18], $urandom, $urandom);
      end
      @(posedge sys_clk);
      #2;
      give_verdict();
   end
endmodule
`default_nettype wire
